// ### hdl/pms_consts.svh
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// address space layout
`define PMS_AW              32
`define PMS_DW              32
`define PMS_PAGE_HI         31
`define PMS_PAGE_LO         24
`define PMS_PAGE_BITS       8
`define PMS_BASE_HI         23
`define PMS_BASE_LO_SMALL   16
`define PMS_BASE_LO_LARGE   18
`define PMS_MB_LO           20
`define PMS_IO_PAGE         8'hff
`define PMS_CSR_AM          6'h15

// modeled array depth in words, address bits taken from the offset
`define PMS_MEM_AW          10
`define PMS_MEM_DEPTH       1024

// control/status word layout
`define PMS_CSR_W           16
`define PMS_CSR_CHK_EN      0
`define PMS_CSR_WRONG_PAR   1
`define PMS_CSR_GEN_INH     2
`define PMS_CSR_SPARE       3
`define PMS_CSR_ERR         15
`define PMS_CSR_RESET       16'h0000
`define PMS_CSR_CTL_MASK    16'h000f

`endif

// ### hdl/pms_pkg.sv
package pms_pkg;

    typedef enum logic [1:0] {
        PMS_IDLE = 2'b00,
        PMS_DONE = 2'b01,
        PMS_WAIT = 2'b11
    } pms_state_e;

    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [5:0]  am;
        logic [31:0] addr;
        logic [3:0]  lanes;
        logic [31:0] wdata;
    } pms_req_s;

    typedef struct packed {
        logic        ack;
        logic        fault_n;
        logic [31:0] rdata;
    } pms_rsp_s;

    typedef struct packed {
        pms_state_e  state;
        logic [15:0] csr;
        pms_rsp_s    rsp;
    } pms_state_s;

endpackage

// ### hdl/pms_slave.sv
// Overview of operation
// - base aligned 256K or 64K in page
// - extended mode selects one of 256 pages
// - 24-bit mode ignores page bits
// - range ends at base plus size, or page
// - register word selectable in FF0000-FFFFFF
// - memory accepts configured address modifier codes other than 15 hex
// - register answers only to modifier 15 hex
// - 16-bit register, msb is parity error
// - low three bits control parity circuitry
// - power-up clears all, system reset bits 0-3 except in the cycle a register write is taken
// - even parity stored with each written byte
// - reads regenerate parity and compare
// - mismatch pulls fault line, sets bit 15
// - fault gated by board enable and software
// - bit 2 inhibits storing computed parity
// - bit 1 writes inverted parity
// - long, word and byte transfers, per-lane parity
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_slave (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  system_wide_reset_n,
    input  wire logic                  large_variant,
    input  wire logic                  extended_mode,
    input  wire logic                  bus_fault_enable,
    input  wire logic [7:0]            page_select,
    input  wire logic [7:0]            base_select,
    input  wire logic [3:0]            size_units,
    input  wire logic [15:1]           csr_select,
    input  wire logic [63:0]           am_accept,
    input  wire pms_pkg::pms_req_s     req,
    output logic                       ack,
    output logic                       bus_fault_line_n,
    output logic [31:0]                rdata,
    output logic [15:0]                csr_status
);

    // ****************************************************
    // state
    // ****************************************************
    pms_pkg::pms_state_s st_r;
    pms_pkg::pms_state_s st_nxt;

    // ****************************************************
    // address decode
    // ****************************************************
    logic        page_hit;
    logic [23:0] base_addr;
    logic [24:0] end_addr;
    logic [24:0] span;
    logic        mem_hit;
    logic        csr_hit;
    logic        am_ok;
    logic [`PMS_MEM_AW-1:0] word_idx;
    logic [23:0] offs;

    always_comb begin
        // 24-bit systems ignore the upper eight bits entirely
        page_hit = !extended_mode
            || (req.addr[`PMS_PAGE_HI:`PMS_PAGE_LO] == page_select);
        if (large_variant) begin
            base_addr = {base_select[5:0], 18'h00000};
            span      = {3'h0, size_units, 18'h00000};
        end else begin
            base_addr = {base_select, 16'h0000};
            span      = {5'h00, size_units, 16'h0000};
        end
        end_addr = {1'b0, base_addr} + span;
        // within one megabyte of the page top the range stops at the boundary
        if (base_addr[`PMS_BASE_HI:`PMS_MB_LO] == 4'hf || end_addr[24]) begin
            end_addr = 25'h1000000;
        end
        offs     = req.addr[23:0] - base_addr;
        word_idx = offs[`PMS_MEM_AW+1:2];
        am_ok    = am_accept[req.am];
        mem_hit  = page_hit && am_ok && (req.am != `PMS_CSR_AM)
            && ({1'b0, req.addr[23:0]} >= {1'b0, base_addr})
            && ({1'b0, req.addr[23:0]} < end_addr);
        csr_hit  = (req.am == `PMS_CSR_AM)
            && (req.addr[23:16] == `PMS_IO_PAGE)
            && (req.addr[15:1] == csr_select);
    end

    // ****************************************************
    // parity
    // ****************************************************
    logic [3:0] wr_par;
    logic [3:0] rd_par;
    logic [3:0] rd_bad;
    logic [31:0] rd_word;
    logic [3:0]  rd_stored;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            // one array per lane so that each lane has a single writing process
            logic [7:0] lane_data_r [`PMS_MEM_DEPTH];
            logic       lane_par_r  [`PMS_MEM_DEPTH];

            assign rd_word[8*g +: 8] = lane_data_r[word_idx];
            assign rd_stored[g]      = lane_par_r[word_idx];

            always_ff @(posedge clock) begin
                if (st_r.state == pms_pkg::PMS_IDLE && req.strobe && mem_hit && req.write
                        && req.lanes[g]) begin
                    lane_data_r[word_idx] <= req.wdata[8*g +: 8];
                    if (!st_r.csr[`PMS_CSR_GEN_INH]) begin
                        lane_par_r[word_idx] <= wr_par[g];
                    end
                end
            end

            // even parity: the stored bit makes the nine-bit group even
            assign wr_par[g] = (^req.wdata[8*g +: 8])
                ^ st_r.csr[`PMS_CSR_WRONG_PAR];
            assign rd_par[g] = ^rd_word[8*g +: 8];
            assign rd_bad[g] = req.lanes[g] && (rd_par[g] != rd_stored[g]);
        end
    endgenerate

    // ****************************************************
    // control and bus answer
    // ****************************************************
    logic rd_err;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.ack     = 1'b0;
        st_nxt.rsp.fault_n = 1'b1;
        rd_err = mem_hit && !req.write && (|rd_bad)
            && st_r.csr[`PMS_CSR_CHK_EN];
        if (!system_wide_reset_n) begin
            st_nxt.csr = st_r.csr & ~`PMS_CSR_CTL_MASK;
        end
        unique case (st_r.state)
            pms_pkg::PMS_IDLE: begin
                if (req.strobe && (mem_hit || csr_hit)) begin
                    st_nxt.state   = pms_pkg::PMS_DONE;
                    st_nxt.rsp.ack = 1'b1;
                    if (csr_hit) begin
                        if (req.write) begin
                            // a write of zero to bit 15 clears the error
                            st_nxt.csr = {req.wdata[15], 11'h000, req.wdata[3:0]};
                        end
                        st_nxt.rsp.rdata = {16'h0000, st_r.csr};
                    end else begin
                        st_nxt.rsp.rdata = req.write ? 32'h00000000 : rd_word;
                    end
                    if (rd_err) begin
                        st_nxt.csr[`PMS_CSR_ERR] = 1'b1;
                        st_nxt.rsp.fault_n = !bus_fault_enable;
                    end
                end
            end
            pms_pkg::PMS_DONE: begin
                st_nxt.state = pms_pkg::PMS_WAIT;
            end
            pms_pkg::PMS_WAIT: begin
                // wait for the master to drop strobe
                if (!req.strobe) begin
                    st_nxt.state = pms_pkg::PMS_IDLE;
                end
            end
            default: st_nxt.state = pms_pkg::PMS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r.state       <= pms_pkg::PMS_IDLE;
            st_r.csr         <= `PMS_CSR_RESET;
            st_r.rsp.ack     <= 1'b0;
            st_r.rsp.fault_n <= 1'b1;
            st_r.rsp.rdata   <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack              = st_r.rsp.ack;
    assign bus_fault_line_n = st_r.rsp.fault_n;
    assign rdata            = st_r.rsp.rdata;
    assign csr_status       = st_r.csr;

endmodule

`default_nettype wire

// ### bench/pms_slave_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pms_slave_sva (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              system_wide_reset_n,
    input wire logic              bus_fault_enable,
    input wire logic [63:0]       am_accept,
    input wire pms_pkg::pms_req_s req,
    input wire logic              ack,
    input wire logic              bus_fault_line_n,
    input wire logic [15:0]       csr_status
);
    logic hit;
    assign hit = req.strobe && (am_accept[req.am] || req.am == 6'h15);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    fault_pulse_a: assert property (!bus_fault_line_n |=> bus_fault_line_n)
        else $error("fault line low too long");
    fault_ack_a: assert property (!bus_fault_line_n |-> ack && csr_status[15])
        else $error("fault without ack or error bit");
    fault_gate_a: assert property (!bus_fault_line_n |-> bus_fault_enable && csr_status[0])
        else $error("fault not enabled");
    am_check_a: assert property ($rose(ack) |-> $past(hit))
        else $error("ack without accepted modifier");
    sys_clear_a: assert property (!system_wide_reset_n |=> csr_status[3:0] == 4'h0)
        else $error("control bits not cleared");
    err_sticky_a: assert property ($fell(csr_status[15]) |-> ack && $past(req.write))
        else $error("error bit dropped");
    err_rise_a: assert property ($rose(csr_status[15]) |-> ack)
        else $error("error bit set without access");
    ctl_hold_a: assert property ($changed(csr_status[3:0]) |->
        ack || !$past(system_wide_reset_n)) else $error("control bits changed");
    cover property (!bus_fault_line_n);
    cover property ($rose(csr_status[15]));
    cover property (ack && req.am == 6'h15);
endmodule
`default_nettype wire

// ### bench/pms_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module pms_bus_master (
    input  wire logic             clock,
    input  wire logic             ack,
    input  wire logic             fault_n,
    input  wire logic [31:0]      rdata,
    output var pms_pkg::pms_req_s req
);
    initial req = '0;
    // holds the request until ack is sampled or eight clocks pass, then releases with junk on the lines
    task automatic cyc(input logic w, input logic [5:0] am, input logic [31:0] a,
        input logic [3:0] ln, input logic [31:0] wd,
        output logic ok, output logic [31:0] rd, output logic fn);
        ok = 1'b0;
        rd = '0;
        fn = 1'b1;
        @(negedge clock);
        req = '{1'b1, w, am, a, ln, wd};
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clock);
            if (ack === 1'b1) begin
                ok = 1'b1;
                rd = rdata;
                fn = fault_n;
            end
        end
        @(negedge clock);
        req = '{1'b0, ~w, ~am, ~a, ~ln, ~wd};
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ### bench/pms_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pms_slave_tb;
    localparam logic [31:0] CA = 32'h00ff0010;
    localparam logic [31:0] MA = 32'h00200040;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              srst_n = 1'b1;
    logic              bfe = 1'b1;
    logic              ext = 1'b0;
    logic              lv = 1'b0;
    logic [7:0]        page = 8'h3c;
    logic [7:0]        base = 8'h20;
    logic [15:1]       csel = 15'h0008;
    pms_pkg::pms_req_s req;
    logic              ack, fault_n, ok, fn;
    logic [31:0]       rdata, rd, w0, w1, a;
    logic [15:0]       csr;
    logic [3:0]        ln;
    int                num_errors = 0;
    int                comparisons = 0;
    always #20 clock = ~clock;
    pms_slave u_pms_slave (.clock(clock), .rst(rst), .system_wide_reset_n(srst_n),
        .large_variant(lv), .extended_mode(ext), .bus_fault_enable(bfe),
        .page_select(page), .base_select(base), .size_units(4'h1), .csr_select(csel),
        .am_accept(64'h1 << 6'h3d), .req(req), .ack(ack), .bus_fault_line_n(fault_n),
        .rdata(rdata), .csr_status(csr));
    pms_bus_master u_pms_bus_master (.clock(clock), .ack(ack), .fault_n(fault_n),
        .rdata(rdata), .req(req));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] l);
        for (int g = 0; g < 4; g++) if (l[g]) o[8*g+:8] = n[8*g+:8];
        return o;
    endfunction
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    // ****
    // main sequence
    // ****
    initial begin
        w0 = $urandom(32'h0ebd);
        repeat (8) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        chk({16'h0, csr}, 32'h0);
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h8005, ok, rd, fn);
        chk({16'h0, csr}, 32'h8005);
        u_pms_bus_master.cyc(1'b0, 6'h15, CA, 4'hf, 32'h0, ok, rd, fn);
        chk({16'h0, rd[15:0]}, 32'h8005);
        u_pms_bus_master.cyc(1'b1, 6'h3d, CA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h0);
        @(negedge clock) srst_n = 1'b0;
        @(negedge clock) srst_n = 1'b1;
        chk({16'h0, csr}, 32'h8000);
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h0001, ok, rd, fn);
        chk({16'h0, csr}, 32'h0001);
        repeat (20) begin
            w0 = $urandom;
            w1 = $urandom;
            ln = 4'($urandom);
            a = $urandom;
            a = {a[31:24], base, 4'h0, a[11:2], 2'b00};
            u_pms_bus_master.cyc(1'b1, 6'h3d, a, 4'hf, w0, ok, rd, fn);
            u_pms_bus_master.cyc(1'b1, 6'h3d, a, ln, w1, ok, rd, fn);
            u_pms_bus_master.cyc(1'b0, 6'h3d, a, 4'hf, 32'h0, ok, rd, fn);
            chk(rd, mrg(w0, w1, ln));
            chk({31'h0, fn}, 32'h1);
        end
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h0003, ok, rd, fn);
        u_pms_bus_master.cyc(1'b1, 6'h3d, MA, 4'hf, w0, ok, rd, fn);
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h0001, ok, rd, fn);
        u_pms_bus_master.cyc(1'b0, 6'h3d, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, fn}, 32'h0);
        chk(rd, w0);
        chk({16'h0, csr}, 32'h8001);
        u_pms_bus_master.cyc(1'b0, 6'h3e, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h0);
        u_pms_bus_master.cyc(1'b0, 6'h3d, 32'h00210000, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h0);
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h0005, ok, rd, fn);
        u_pms_bus_master.cyc(1'b1, 6'h3d, MA, 4'hf, w0, ok, rd, fn);
        @(negedge clock) bfe = 1'b0;
        u_pms_bus_master.cyc(1'b0, 6'h3d, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, fn}, 32'h1);
        chk({16'h0, csr}, 32'h8005);
        @(negedge clock) bfe = 1'b1;
        u_pms_bus_master.cyc(1'b0, 6'h3d, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, fn}, 32'h0);
        u_pms_bus_master.cyc(1'b1, 6'h15, CA, 4'hf, 32'h0000, ok, rd, fn);
        u_pms_bus_master.cyc(1'b0, 6'h3d, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, fn}, 32'h1);
        chk({16'h0, csr}, 32'h0000);
        @(negedge clock) ext = 1'b1;
        u_pms_bus_master.cyc(1'b0, 6'h3d, {8'h3c, MA[23:0]}, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h1);
        u_pms_bus_master.cyc(1'b0, 6'h3d, MA, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h0);
        @(negedge clock) ext = 1'b0;
        lv = 1'b1;
        u_pms_bus_master.cyc(1'b0, 6'h3d, 32'h00800000, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h1);
        u_pms_bus_master.cyc(1'b0, 6'h3d, 32'h00840000, 4'hf, 32'h0, ok, rd, fn);
        chk({31'h0, ok}, 32'h0);
        final_report();
    end
endmodule
bind pms_slave pms_slave_sva u_pms_slave_sva (.clock(clock), .rst(rst),
    .system_wide_reset_n(system_wide_reset_n), .bus_fault_enable(bus_fault_enable),
    .am_accept(am_accept), .req(req), .ack(ack), .bus_fault_line_n(bus_fault_line_n),
    .csr_status(csr_status));
`default_nettype wire
